//--- logic/pdiv_pkg.sv
// constants and carrier types for the peripheral decode and vector block
package pdiv_pkg;

    // bus widths
    localparam int ADR_W = 16;
    localparam int DAT_W = 8;
    localparam int OFF_W = 8;

    // i/o regions
    localparam logic [15:0] SHORT_IO_LAST = 16'h003F;
    localparam logic [15:0] EXT_IO_LAST = 16'h103F;

    // interrupt controller window holding this block's own registers
    localparam logic [15:0] IRQC_BASE = 16'h0110;
    localparam logic [15:0] IRQC_SIZE = 16'h0010;
    localparam logic [7:0] OFF_FLAG = 8'h00;
    localparam logic [7:0] OFF_ENABLE = 8'h01;
    localparam logic [7:0] OFF_CLEAR = 8'h02;
    localparam logic [7:0] OFF_GLOBAL = 8'h03;
    localparam int GIE_POS = 0;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] GLOBAL_RST = 8'h00;

    // peripheral windows, index is the select bit
    localparam int NPER = 12;
    localparam int SEL_GPR = 0;
    localparam int SEL_CRC = 1;
    localparam int SEL_NVM = 2;
    localparam int SEL_TMR0 = 3;
    localparam int SEL_TMR1 = 4;
    localparam int SEL_TMR2 = 5;
    localparam int SEL_SER0 = 6;
    localparam int SEL_SER1 = 7;
    localparam int SEL_LOCK = 8;
    localparam int SEL_FUSE = 9;
    localparam int SEL_UROW = 10;
    localparam int SEL_SROW = 11;
    localparam logic [15:0] WIN_BASE [NPER] = '{
        16'h001C, 16'h0120, 16'h1000, 16'h0B00, 16'h0B10, 16'h0B20,
        16'h0800, 16'h0820, 16'h1040, 16'h1050, 16'h1080, 16'h1100};
    localparam logic [15:0] WIN_SIZE [NPER] = '{
        16'h0004, 16'h0010, 16'h0040, 16'h0010, 16'h0010, 16'h0010,
        16'h0020, 16'h0020, 16'h0010, 16'h0010, 16'h0020, 16'h0080};

    // vector numbers and program word addresses
    localparam int VEC_W = 2;
    localparam int VADR_W = 8;
    localparam logic [1:0] VEC_RESET = 2'h0;
    localparam logic [1:0] VEC_NMI = 2'h1;
    localparam logic [1:0] VEC_VLM = 2'h2;
    localparam logic [7:0] VADR_RESET = 8'h00;
    localparam logic [7:0] VADR_NMI = 8'h02;
    localparam logic [7:0] VADR_VLM = 8'h04;

    // access forwarded to the selected peripheral
    typedef struct packed {
        logic stb;
        logic we;
        logic [OFF_W-1:0] off;
        logic [DAT_W-1:0] wdata;
    } pdiv_per_req_t;

    // request held while the bus cycle is in flight
    typedef struct packed {
        logic [ADR_W-1:0] adr;
        logic we;
        logic [DAT_W-1:0] wdata;
    } pdiv_bus_req_t;

endpackage

//--- logic/pdiv_top.sv
// peripheral address decoder and interrupt vector request mapping
// Behaviour
// [R1] a source flag sets on its event even while that source is disabled
// [R2] each source owns one enable bit, written by software to switch it
// [R3] a source requests only while both its enable and its flag are set
// [R4] no request is raised unless the global interrupt enable is also set
// [R5] a request holds until its flag is cleared; servicing does not drop it
// [R6] each vector belongs to one instance; its several sources share it
// [R7] vector 0 at word 0x00, vector 1 at 0x02, vector 2 at 0x04
// [R8] select scratch block at 0x001C and interrupt controller at 0x0110
// [R9] select checksum scanner at 0x0120 and nonvolatile controller at 0x1000
// [R10] three type-b timers at 0x0B00, 0x0B10, 0x0B20, 16 bytes each
// [R11] two serial ports at 0x0800 and 0x0820
// [R12] lock 0x1040, fuses 0x1050, user row 0x1080, signature row 0x1100
// [R13] short i/o form reaches 0x00-0x3F only; rest by load and store
// [R14] unmapped addresses select nothing, read zero, ignore writes
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

module pdiv_top #(
    parameter int NSRC = 2
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic WB_SEL_I,
    input wire logic WB_TGA_I,
    input wire logic [pdiv_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [pdiv_pkg::DAT_W-1:0] WB_DAT_I,
    output logic [pdiv_pkg::DAT_W-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [pdiv_pkg::NPER-1:0] PER_SEL,
    output pdiv_pkg::pdiv_per_req_t PER_REQ,
    input wire logic [pdiv_pkg::DAT_W-1:0] PER_RDATA,
    input wire logic [NSRC-1:0] VLM_EVENT,
    input wire logic NMI_PIN,
    output logic IRQ,
    output logic [2:0] VEC_REQ,
    output logic VEC_VALID,
    output logic [pdiv_pkg::VEC_W-1:0] VEC_NUM,
    output logic [pdiv_pkg::VADR_W-1:0] VEC_ADDR
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // true when an address falls inside a base/size window
    function automatic logic in_win(
        input logic [15:0] a,
        input logic [15:0] base,
        input logic [15:0] size
    );
        logic [15:0] rel;
        rel = 16'(a - base);
        return (a >= base) && (rel < size);
    endfunction

    // one-hot peripheral select; short i/o form is cut off above 0x3F
    function automatic logic [pdiv_pkg::NPER-1:0] per_hit(
        input logic [15:0] a,
        input logic short_io
    );
        logic [pdiv_pkg::NPER-1:0] h;
        h = '0;
        for (int i = 0; i < pdiv_pkg::NPER; i++)
        begin
            h[i] = in_win(a, pdiv_pkg::WIN_BASE[i], pdiv_pkg::WIN_SIZE[i]);
        end
        if (short_io && (a > pdiv_pkg::SHORT_IO_LAST))
        begin
            h = '0; // [R13]
        end
        return h;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus cycle sequencing

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACK} pdiv_state_t;

    pdiv_state_t state_q;
    pdiv_pkg::pdiv_bus_req_t req;
    logic take;
    logic [pdiv_pkg::NPER-1:0] hit;
    logic ctrl_hit;
    logic [pdiv_pkg::OFF_W-1:0] ctrl_off;
    logic [pdiv_pkg::OFF_W-1:0] per_off;
    logic own_q;
    logic [pdiv_pkg::DAT_W-1:0] own_rdata;

    // request taken once per cycle, only while idle
    assign take = WB_CYC_I && WB_STB_I && (state_q == ST_IDLE);
    assign req.adr = WB_ADR_I;
    assign req.we = WB_WE_I && WB_SEL_I;
    assign req.wdata = WB_DAT_I;
    assign hit = per_hit(req.adr, WB_TGA_I); // [R8] [R9] [R10] [R11] [R12]
    assign ctrl_hit = in_win(req.adr, pdiv_pkg::IRQC_BASE,
        pdiv_pkg::IRQC_SIZE) && !(WB_TGA_I
        && (req.adr > pdiv_pkg::SHORT_IO_LAST)); // [R8] [R13]
    assign ctrl_off = 8'(req.adr - pdiv_pkg::IRQC_BASE);

    // offset inside whichever window was hit
    always_comb
    begin
        per_off = '0;
        for (int i = 0; i < pdiv_pkg::NPER; i++)
        begin
            if (hit[i])
            begin
                per_off = 8'(req.adr - pdiv_pkg::WIN_BASE[i]);
            end
        end
    end

    // three-step sequence keeps ack a single cycle wide
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (take)
                    begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    state_q <= ST_ACK;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // forwarded strobe lasts one cycle; select holds until the ack
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            PER_SEL <= '0;
            PER_REQ <= '0;
            own_q <= 1'b0;
        end
        else if (take)
        begin
            PER_SEL <= hit; // [R14]
            PER_REQ.stb <= |hit;
            PER_REQ.we <= req.we && (|hit); // [R14]
            PER_REQ.off <= per_off;
            PER_REQ.wdata <= req.wdata;
            own_q <= ctrl_hit;
        end
        else
        begin
            PER_REQ.stb <= 1'b0;
            if (state_q == ST_ACK)
            begin
                PER_SEL <= '0;
                own_q <= 1'b0;
            end
        end
    end

    // answer: peripheral data, own register, or zero when unmapped
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end
        else
        begin
            WB_ACK_O <= (state_q == ST_WAIT);
            if (state_q == ST_WAIT)
            begin
                if (own_q)
                begin
                    WB_DAT_O <= own_rdata;
                end
                else if (|PER_SEL)
                begin
                    WB_DAT_O <= PER_RDATA;
                end
                else
                begin
                    WB_DAT_O <= '0; // [R14]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt controller registers

    logic [NSRC-1:0] flag_q;
    logic [NSRC-1:0] enable_q;
    logic gie_q;
    logic [pdiv_pkg::OFF_W-1:0] own_off_q;
    logic own_wr;
    logic [NSRC-1:0] clr;

    assign own_wr = take && ctrl_hit && req.we;
    assign clr = (own_wr && (ctrl_off == pdiv_pkg::OFF_CLEAR))
        ? req.wdata[NSRC-1:0] : '0;

    // keep the offset for the read answer
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            own_off_q <= '0;
        end
        else if (take)
        begin
            own_off_q <= ctrl_off;
        end
    end

    // flags set on events whatever the enable; set beats a clear
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            flag_q <= '0;
        end
        else
        begin
            flag_q <= (flag_q & ~clr) | VLM_EVENT; // [R1] [R5]
        end
    end

    // per-source enables
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            enable_q <= pdiv_pkg::ENABLE_RST[NSRC-1:0];
        end
        else if (own_wr && (ctrl_off == pdiv_pkg::OFF_ENABLE))
        begin
            enable_q <= req.wdata[NSRC-1:0]; // [R2]
        end
    end

    // global enable
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            gie_q <= pdiv_pkg::GLOBAL_RST[pdiv_pkg::GIE_POS];
        end
        else if (own_wr && (ctrl_off == pdiv_pkg::OFF_GLOBAL))
        begin
            gie_q <= req.wdata[pdiv_pkg::GIE_POS];
        end
    end

    // read mux; clear register reads as zero
    always_comb
    begin
        own_rdata = '0;
        if (own_off_q == pdiv_pkg::OFF_FLAG)
        begin
            own_rdata[NSRC-1:0] = flag_q;
        end
        else if (own_off_q == pdiv_pkg::OFF_ENABLE)
        begin
            own_rdata[NSRC-1:0] = enable_q;
        end
        else if (own_off_q == pdiv_pkg::OFF_GLOBAL)
        begin
            own_rdata[pdiv_pkg::GIE_POS] = gie_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // vector requests

    logic nmi_meta_q;
    logic nmi_sync_q;
    logic vlm_req;

    // pin crosses in from outside, two flops before use
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            nmi_meta_q <= 1'b0;
            nmi_sync_q <= 1'b0;
        end
        else
        begin
            nmi_meta_q <= NMI_PIN;
            nmi_sync_q <= nmi_meta_q;
        end
    end

    // all monitor sources share one vector line
    assign vlm_req = gie_q && (|(flag_q & enable_q)); // [R3] [R4] [R6]

    // per-vector request lines; no service input, so only a flag clear or clearing its enable or the global enable drops it
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            VEC_REQ <= 3'h1;
            IRQ <= 1'b0;
        end
        else
        begin
            VEC_REQ <= {vlm_req, nmi_sync_q, 1'b0}; // [R5] [R6]
            IRQ <= vlm_req;
        end
    end

    // lowest pending vector with its program word address
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            VEC_VALID <= 1'b1;
            VEC_NUM <= pdiv_pkg::VEC_RESET; // [R7]
            VEC_ADDR <= pdiv_pkg::VADR_RESET;
        end
        else if (nmi_sync_q)
        begin
            VEC_VALID <= 1'b1;
            VEC_NUM <= pdiv_pkg::VEC_NMI;
            VEC_ADDR <= pdiv_pkg::VADR_NMI; // [R7]
        end
        else if (vlm_req)
        begin
            VEC_VALID <= 1'b1;
            VEC_NUM <= pdiv_pkg::VEC_VLM;
            VEC_ADDR <= pdiv_pkg::VADR_VLM; // [R7]
        end
        else
        begin
            VEC_VALID <= 1'b0;
            VEC_NUM <= pdiv_pkg::VEC_RESET;
            VEC_ADDR <= pdiv_pkg::VADR_RESET;
        end
    end

endmodule

`default_nettype wire

//--- verification/pdiv_checker.sv
// assertions on the decoder and vector block ports
`timescale 1ns/10ps
`default_nettype none
module pdiv_checker (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_TGA_I,
    input wire logic [15:0] WB_ADR_I,
    input wire logic [7:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic [11:0] PER_SEL,
    input wire pdiv_pkg::pdiv_per_req_t PER_REQ,
    input wire logic [7:0] PER_RDATA,
    input wire logic NMI_PIN,
    input wire logic IRQ,
    input wire logic [2:0] VEC_REQ,
    input wire logic VEC_VALID,
    input wire logic [1:0] VEC_NUM,
    input wire logic [7:0] VEC_ADDR
);
    logic req;
    // single domain, so one clock and one reset serve all
    default clocking dc @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    assign req = WB_CYC_I && WB_STB_I;
    ////////////////////////////////////////////////////////////////////
    // bus answer timing
    chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held past one cycle");
    chk_ack_bound: assert property (req |-> ##[0:3] WB_ACK_O)
        else $error("bus cycle not answered");
    // decode: at most one window, short form stops at the low region
    chk_sel_onehot: assert property ($onehot0(PER_SEL))
        else $error("several windows selected");
    chk_short_form: assert property (
        req && WB_TGA_I && WB_ADR_I > 16'h003F |=> PER_SEL == 12'h000)
        else $error("short form reached above low region");
    chk_stb_pulse: assert property (PER_REQ.stb |=> !PER_REQ.stb)
        else $error("peripheral strobe longer than one cycle");
    chk_rd_pass: assert property (PER_REQ.stb && !PER_REQ.we &&
        |PER_SEL |=> WB_ACK_O && WB_DAT_O == $past(PER_RDATA))
        else $error("read data not passed back");
    // vectors and request
    chk_vec_word: assert property (
        VEC_VALID |-> VEC_ADDR == {5'h00, VEC_NUM, 1'h0})
        else $error("vector address not twice its number");
    chk_irq_vector: assert property (IRQ == VEC_REQ[2])
        else $error("request and monitor vector disagree");
    chk_irq_hold: assert property (IRQ && !WB_CYC_I |=> IRQ)
        else $error("request dropped without a clear");
    chk_nmi_vec: assert property (NMI_PIN [*4] |->
        VEC_VALID && VEC_NUM == 2'h1)
        else $error("nmi vector not presented");
    cov_read: cover property (PER_REQ.stb && !PER_REQ.we);
    cov_irq: cover property ($rose(IRQ));
    cov_nmi: cover property (VEC_VALID && VEC_NUM == 2'h1);
endmodule
bind pdiv_top pdiv_checker pdiv_checker_inst (
    .CORE_CLK(CORE_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_TGA_I(WB_TGA_I), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PER_SEL(PER_SEL),
    .PER_REQ(PER_REQ), .PER_RDATA(PER_RDATA), .NMI_PIN(NMI_PIN),
    .IRQ(IRQ), .VEC_REQ(VEC_REQ), .VEC_VALID(VEC_VALID),
    .VEC_NUM(VEC_NUM), .VEC_ADDR(VEC_ADDR));
`default_nettype wire

//--- verification/pdiv_per_model.sv
// far-side peripheral model answering forwarded reads
`timescale 1ns/10ps
`default_nettype none
module pdiv_per_model (
    input wire logic clk,
    input wire logic [11:0] sel,
    input wire pdiv_pkg::pdiv_per_req_t req,
    output logic [7:0] rdata
);
    logic [7:0] noise_q = 8'hA5;
    // idle data keeps moving so a stale value never looks right
    always_ff @(posedge clk)
    begin
        noise_q <= noise_q + 8'h5B;
    end
    // answer names the window index and the low offset bits
    always_comb
    begin
        rdata = noise_q;
        for (int i = 0; i < 12; i++)
            if (req.stb && !req.we && sel[i])
                rdata = {i[3:0], req.off[3:0]};
    end
endmodule
`default_nettype wire

//--- verification/tb_pdiv_top.sv
// self-checking bench for the decoder and vector block
`timescale 1ns/10ps
`default_nettype none
module tb_pdiv_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic tga = 1'b0;
    logic sel = 1'b0;
    // qualifiers that the next bus cycle raises together with cyc
    logic wtga = 1'b0;
    logic wsel = 1'b1;
    logic [15:0] adr = 16'h0000;
    logic [7:0] dat = 8'h00;
    logic [1:0] vlm = 2'h0;
    logic nmi = 1'b0;
    logic [7:0] dat_o;
    logic [7:0] per_rd;
    logic [7:0] vaddr;
    logic [11:0] per_sel;
    logic [2:0] vreq;
    logic [1:0] vnum;
    logic ack;
    logic irq;
    logic vvalid;
    pdiv_pkg::pdiv_per_req_t per_req;
    int errors = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h00012997;
    logic [28:0] q_per[$];
    logic [7:0] q_rd[$];
    localparam logic [15:0] BASE [12] = '{
        16'h001C, 16'h0120, 16'h1000, 16'h0B00, 16'h0B10, 16'h0B20,
        16'h0800, 16'h0820, 16'h1040, 16'h1050, 16'h1080, 16'h1100};
    always #4 clk = ~clk;
    pdiv_top pdiv_top_inst (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_SEL_I(sel), .WB_TGA_I(tga),
        .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .PER_SEL(per_sel), .PER_REQ(per_req), .PER_RDATA(per_rd),
        .VLM_EVENT(vlm), .NMI_PIN(nmi), .IRQ(irq), .VEC_REQ(vreq),
        .VEC_VALID(vvalid), .VEC_NUM(vnum), .VEC_ADDR(vaddr));
    pdiv_per_model pdiv_per_model_inst (.clk(clk), .sel(per_sel),
        .req(per_req), .rdata(per_rd));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [28:0] seen, input logic [28:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic [15:0] a, input logic w,
        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        sel <= wsel;
        tga <= wtga;
        adr <= a;
        we <= w;
        dat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 16);
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 1'b0;
        tga <= 1'b0;
        if (n >= 16)
        begin
            errors++;
            give_verdict();
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        q_rd.push_back(e);
        wb(a, 1'b0, 8'h00);
    endtask
    // notes what the decoder must do, then runs the access
    task automatic acc(input logic [15:0] a, input logic w,
        input logic [7:0] d, input logic t);
        int k;
        logic [15:0] off;
        k = -1;
        off = 16'h0000;
        for (int i = 0; i < 12; i++)
            if (a >= BASE[i] && a - BASE[i] < pdiv_pkg::WIN_SIZE[i] &&
                (!t || a <= 16'h003F))
            begin
                k = i;
                off = a - BASE[i];
            end
        if (k >= 0)
            q_per.push_back({12'h001 << k, w, off[7:0], w ? d : 8'h00});
        if (!w)
            q_rd.push_back(k >= 0 ? {k[3:0], off[3:0]} : 8'h00);
        wtga = t;
        wb(a, w, d);
        wtga = 1'b0;
    endtask
    task automatic pulse(input logic [1:0] v);
        @(posedge clk);
        vlm <= v;
        @(posedge clk);
        vlm <= 2'h0;
        repeat (2) @(posedge clk);
    endtask
    // e holds irq, vector lines, valid, number and word address
    task automatic vec(input logic [14:0] e);
        repeat (2) @(posedge clk);
        check({14'h0000, irq, vreq, vvalid, vnum, vaddr},
            {14'h0000, e});
    endtask
    // results are taken off the notes as they appear
    always @(posedge clk)
    begin
        if (per_req.stb === 1'b1 && per_sel !== 12'h000)
            check({per_sel, per_req.we, per_req.off,
                per_req.we ? per_req.wdata : 8'h00},
                q_per.size() > 0 ? q_per.pop_front() : 29'hX);
        if (ack === 1'b1 && we === 1'b0)
            check({21'h000000, dat_o},
                {21'h000000, q_rd.size() > 0 ? q_rd.pop_front() : 8'hXX});
    end
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] r;
        logic [15:0] a;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 12; i++)
        begin
            r = xs();
            acc(BASE[i], 1'b0, 8'h00, 1'b0);
            acc(BASE[i] + pdiv_pkg::WIN_SIZE[i] - 16'h0001, 1'b0, 8'h00,
                1'b0);
            acc(BASE[i] + pdiv_pkg::WIN_SIZE[i], 1'b0, 8'h00, 1'b0);
            acc(BASE[i] + 16'h0002, 1'b1, r[7:0], 1'b0);
        end
        acc(16'h001D, 1'b0, 8'h00, 1'b1);
        repeat (60)
        begin
            r = xs();
            a = r[15] ? BASE[r[19:16] % 12] + {9'h000, r[26:20]}
                : {3'h0, r[12:0]};
            if (a[15:4] != 12'h011)
                acc(a, r[13], r[23:16], r[14]);
        end
        $display("test decode done");
        pulse(2'h1);
        rd(16'h0110, 8'h01);
        wb(16'h0111, 1'b1, 8'h01);
        vec(15'h0000);
        wb(16'h0113, 1'b1, 8'h01);
        vec(15'h6604);
        repeat (20) @(posedge clk);
        vec(15'h6604);
        nmi <= 1'b1;
        repeat (2) @(posedge clk);
        vec(15'h7502);
        nmi <= 1'b0;
        repeat (2) @(posedge clk);
        vec(15'h6604);
        pulse(2'h2);
        rd(16'h0110, 8'h03);
        wb(16'h0112, 1'b1, 8'h01);
        rd(16'h0112, 8'h00);
        vec(15'h0000);
        wb(16'h0111, 1'b1, 8'h02);
        vec(15'h6604);
        wb(16'h0111, 1'b1, 8'h00);
        vec(15'h0000);
        wb(16'h0111, 1'b1, 8'h02);
        // a write without its byte select must leave the enable alone
        wsel = 1'b0;
        wb(16'h0111, 1'b1, 8'h01);
        wsel = 1'b1;
        rd(16'h0111, 8'h02);
        vec(15'h6604);
        $display("test interrupt done");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        check({14'h0000, irq, vreq, vvalid, vnum, vaddr}, 29'h0C00);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(16'h0111, 8'h00);
        rd(16'h0110, 8'h00);
        repeat (4) @(posedge clk);
        check(q_per.size() + q_rd.size(), 29'h0);
        $display("test reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
